// File: fbs_status.sv
// Purpose: Global state field and per-node diagnostic flags of the master.
// Assumes: All inputs except arst_n are synchronous to ref_clk and come from the
//          master's own protocol logic.
// Notes: Every output is a register or, for operate and the dup flags, a decode of one; nothing the host reads changes state.
`timescale 1ns/10ps
`include "fbs_defs.svh"
module fbs_status (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic run_req,
    input wire logic dup_check_start,
    input wire logic dup_node_seen,
    input wire logic dup_same_addr,
    input wire logic host_operative,
    input wire logic can_error,
    input wire logic can_bus_off,
    input wire logic can_warn_limit,
    input wire logic telegram_rejected,
    input wire logic severe_bus_error,
    input wire logic auto_clear_end,
    input wire logic param_error,
    input wire logic err_valid,
    input wire logic [`FBS_ADDR_W-1:0] err_node,
    input wire logic [`FBS_CODE_W-1:0] err_code_in,
    input wire logic [`FBS_NODES-1:0] cfg_nodes,
    input wire logic [`FBS_NODES-1:0] cfg_deact,
    input wire logic [`FBS_NODES-1:0] present_nodes,
    input wire logic [`FBS_NODES-1:0] exchanging_nodes,
    input wire logic [`FBS_NODES-1:0] ucmm_required,
    input wire logic chk_valid,
    input wire logic [`FBS_ADDR_W-1:0] chk_node,
    input wire logic [`FBS_ID_W-1:0] chk_cfg_id,
    input wire logic [`FBS_ID_W-1:0] chk_act_id,
    input wire logic [`FBS_SIZE_W-1:0] chk_cfg_size,
    input wire logic [`FBS_SIZE_W-1:0] chk_act_size,
    input wire logic emcy_push,
    input wire logic emcy_pop,
    input wire logic [`FBS_ADDR_W-1:0] emcy_node,
    output logic operate,
    output logic dup_check_active,
    output logic dup_address_found,
    output logic host_not_ready,
    output logic bus_event_seen,
    output logic fatal_bus_error,
    output logic node_not_exchanging,
    output logic auto_clear_stop,
    output logic ctrl_error,
    output logic [`FBS_CNT_W-1:0] bus_off_cnt,
    output logic [`FBS_CNT_W-1:0] warn_cnt,
    output logic [`FBS_CNT_W-1:0] bus_err_cnt,
    output logic [`FBS_CNT_W-1:0] reject_cnt,
    output logic [`FBS_ADDR_W-1:0] err_addr,
    output logic [`FBS_CODE_W-1:0] err_code,
    output logic [`FBS_NODES-1:0] no_resp,
    output logic [`FBS_NODES-1:0] emcy_ovf,
    output logic [`FBS_NODES-1:0] param_fault,
    output logic [`FBS_NODES-1:0] cfg_fault,
    output logic [`FBS_NODES-1:0] ucmm,
    output logic [`FBS_NODES-1:0] deact,
    output logic [`FBS_NODES-1:0] param_nodes,
    output logic [`FBS_NODES-1:0] active_nodes,
    output logic [`FBS_NODES-1:0] diag_nodes
);

    ////////////////////////////////////////////////////////////////////////
    fbs_pkg::fbs_state_t st;
    fbs_pkg::fbs_state_t next_st;
    logic [`FBS_NODES-1:0] next_active;
    logic [`FBS_NODES-1:0] next_param;

    function automatic logic [`FBS_CNT_W-1:0] sat_inc(
        input logic [`FBS_CNT_W-1:0] v);
        // Counters saturate so a long error burst never wraps to zero.
        sat_inc = (&v) ? v : v + `FBS_CNT_W'(1);
    endfunction : sat_inc

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [`FBS_EMCY_W-1:0] fill;
        fill = '0;
        next_st = st;
        next_st.main_state = run_req ? fbs_pkg::FBS_OPERATE
                                     : fbs_pkg::FBS_STOP;
        unique case (st.dup)
            fbs_pkg::FBS_DUP_IDLE: begin
                if (dup_check_start) begin
                    next_st.dup = fbs_pkg::FBS_DUP_RUN;
                end
            end
            fbs_pkg::FBS_DUP_RUN: begin
                if (dup_same_addr) begin
                    next_st.dup = fbs_pkg::FBS_DUP_FAIL;
                end else if (dup_node_seen) begin
                    next_st.dup = fbs_pkg::FBS_DUP_DONE;
                end
            end
            fbs_pkg::FBS_DUP_DONE: begin
                if (dup_check_start) begin
                    next_st.dup = fbs_pkg::FBS_DUP_RUN;
                end
            end
            fbs_pkg::FBS_DUP_FAIL: begin
                next_st.dup = fbs_pkg::FBS_DUP_FAIL;
            end
        endcase
        next_st.host_not_ready = !host_operative;
        if (can_error) begin
            next_st.bus_event_seen = 1'b1;
            next_st.bus_err_cnt = sat_inc(st.bus_err_cnt);
        end
        if (can_error && can_bus_off) begin
            next_st.bus_off_cnt = sat_inc(st.bus_off_cnt);
        end
        if (can_error && can_warn_limit) begin
            next_st.warn_cnt = sat_inc(st.warn_cnt);
        end
        if (telegram_rejected) begin
            next_st.reject_cnt = sat_inc(st.reject_cnt);
        end
        if (severe_bus_error) begin
            next_st.fatal_bus_error = 1'b1;
        end
        next_st.node_not_exchanging =
            |(cfg_nodes & ~cfg_deact & ~exchanging_nodes);
        if (auto_clear_end) begin
            next_st.auto_clear_stop = 1'b1;
        end
        if (param_error) begin
            next_st.ctrl_error = 1'b1;
        end
        if (err_valid) begin
            next_st.err_addr = err_node;
            next_st.err_code = err_code_in;
        end
        next_st.no_resp = cfg_nodes & ~cfg_deact & ~present_nodes;
        next_st.ucmm = cfg_nodes & ucmm_required;
        next_st.deact = cfg_nodes & cfg_deact;
        if (chk_valid) begin
            next_st.param_fault[chk_node] =
                (chk_cfg_id != chk_act_id);
            next_st.cfg_fault[chk_node] =
                (chk_cfg_size != chk_act_size);
        end
        // Fill level per node; a push without a pop into a full buffer is the overflow.
        if (emcy_push || emcy_pop) begin
            fill = st.emcy_fill[emcy_node*`FBS_EMCY_W +: `FBS_EMCY_W];
            if (emcy_push && !emcy_pop) begin
                if (fill == `FBS_EMCY_W'(`FBS_EMCY_DEPTH)) begin
                    next_st.emcy_ovf[emcy_node] = 1'b1;
                end else begin
                    fill = fill + `FBS_EMCY_W'(1);
                end
            end else if (!emcy_push && fill != '0) begin
                fill = fill - `FBS_EMCY_W'(1);
            end
            next_st.emcy_fill[emcy_node*`FBS_EMCY_W +: `FBS_EMCY_W] = fill;
        end
        next_st.diag = next_st.no_resp | next_st.emcy_ovf
                     | next_st.param_fault | next_st.cfg_fault;
        next_param = cfg_nodes;
        next_active = cfg_nodes & ~cfg_deact;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reading the outputs is passive; no flag is cleared by the host.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.host_not_ready <= 1'b1;
            param_nodes <= '0;
            active_nodes <= '0;
        end else begin
            st <= next_st;
            param_nodes <= next_param;
            active_nodes <= next_active;
        end
    end

    assign operate = (st.main_state == fbs_pkg::FBS_OPERATE);
    assign dup_check_active = (st.dup == fbs_pkg::FBS_DUP_RUN);
    assign dup_address_found = (st.dup == fbs_pkg::FBS_DUP_FAIL);
    assign host_not_ready = st.host_not_ready;
    assign bus_event_seen = st.bus_event_seen;
    assign fatal_bus_error = st.fatal_bus_error;
    assign node_not_exchanging = st.node_not_exchanging;
    assign auto_clear_stop = st.auto_clear_stop;
    assign ctrl_error = st.ctrl_error;
    assign bus_off_cnt = st.bus_off_cnt;
    assign warn_cnt = st.warn_cnt;
    assign bus_err_cnt = st.bus_err_cnt;
    assign reject_cnt = st.reject_cnt;
    assign err_addr = st.err_addr;
    assign err_code = st.err_code;
    assign no_resp = st.no_resp;
    assign emcy_ovf = st.emcy_ovf;
    assign param_fault = st.param_fault;
    assign cfg_fault = st.cfg_fault;
    assign ucmm = st.ucmm;
    assign deact = st.deact;
    assign diag_nodes = st.diag;

    ////////////////////////////////////////////////////////////////////////
    property p_event_sticky;
        @(posedge ref_clk) disable iff (!arst_n)
        bus_event_seen |=> bus_event_seen;
    endproperty
    a_event_sticky: assert property (p_event_sticky)
        else $error("bus event flag cleared");

    property p_event_set;
        @(posedge ref_clk) disable iff (!arst_n)
        can_error |=> bus_event_seen && $changed(bus_err_cnt) || &bus_err_cnt;
    endproperty
    a_event_set: assert property (p_event_set)
        else $error("can error not recorded");

    property p_dup_fail;
        @(posedge ref_clk) disable iff (!arst_n)
        dup_check_active && dup_same_addr
            |=> dup_address_found && !dup_check_active;
    endproperty
    a_dup_fail: assert property (p_dup_fail)
        else $error("duplicate address not flagged");

    property p_dup_done;
        @(posedge ref_clk) disable iff (!arst_n)
        dup_check_active && dup_node_seen && !dup_same_addr
            |=> !dup_check_active && !dup_address_found;
    endproperty
    a_dup_done: assert property (p_dup_done)
        else $error("duplicate check did not end");

    property p_host;
        @(posedge ref_clk) disable iff (!arst_n)
        !host_operative |=> host_not_ready;
    endproperty
    a_host: assert property (p_host)
        else $error("host not ready flag missing");

    property p_fatal;
        @(posedge ref_clk) disable iff (!arst_n)
        severe_bus_error |=> fatal_bus_error [*2];
    endproperty
    a_fatal: assert property (p_fatal)
        else $error("fatal flag not held");

    property p_auto_clear_stop;
        @(posedge ref_clk) disable iff (!arst_n)
        auto_clear_end |=> auto_clear_stop;
    endproperty
    a_auto_clear_stop: assert property (p_auto_clear_stop)
        else $error("auto clear flag missing");

    property p_ctrl;
        @(posedge ref_clk) disable iff (!arst_n)
        param_error |=> ctrl_error;
    endproperty
    a_ctrl: assert property (p_ctrl)
        else $error("control error flag missing");

    property p_node_not_exchanging;
        @(posedge ref_clk) disable iff (!arst_n)
        |(cfg_nodes & ~cfg_deact & ~exchanging_nodes) |=> node_not_exchanging;
    endproperty
    a_node_not_exchanging: assert property (p_node_not_exchanging)
        else $error("non exchange flag missing");

    property p_cfg;
        @(posedge ref_clk) disable iff (!arst_n)
        chk_valid && chk_cfg_size != chk_act_size
            |=> cfg_fault[$past(chk_node)];
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("configuration fault missing");

    property p_main;
        @(posedge ref_clk) disable iff (!arst_n)
        run_req |=> operate;
    endproperty
    a_main: assert property (p_main)
        else $error("operate state not reported");

    property p_param;
        @(posedge ref_clk) disable iff (!arst_n)
        chk_valid && chk_cfg_id != chk_act_id
            |=> param_fault[$past(chk_node)];
    endproperty
    a_param: assert property (p_param)
        else $error("parameterization fault missing");

    property p_ovf_sticky;
        @(posedge ref_clk) disable iff (!arst_n)
        1'b1 |=> (emcy_ovf & $past(emcy_ovf)) == $past(emcy_ovf);
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky)
        else $error("overflow flag cleared");

    property p_ucmm;
        @(posedge ref_clk) disable iff (!arst_n)
        |(cfg_nodes & ucmm_required) |=> |ucmm;
    endproperty
    a_ucmm: assert property (p_ucmm)
        else $error("ucmm support flag missing");

    property p_deact;
        @(posedge ref_clk) disable iff (!arst_n)
        |(cfg_nodes & cfg_deact) |=> |deact;
    endproperty
    a_deact: assert property (p_deact)
        else $error("deactivated flag missing");

    property p_no_resp;
        @(posedge ref_clk) disable iff (!arst_n)
        |(cfg_nodes & ~cfg_deact & ~present_nodes) |=> |no_resp;
    endproperty
    a_no_resp: assert property (p_no_resp)
        else $error("no response flag missing");

    property p_diag;
        @(posedge ref_clk) disable iff (!arst_n)
        |emcy_ovf |-> |diag_nodes;
    endproperty
    a_diag: assert property (p_diag)
        else $error("diagnostic bitmap missing a node");

endmodule : fbs_status

// File: fbs_defs.svh
// Purpose: Constants for the fieldbus master status flag block.
// Assumes: 64 node addresses, 16-bit event counters.
// Notes: Widths and sizes only; the package holds the types.
//
// Contract
// - Main state reported as exactly operate or stop.
// - Duplicate check flag active until another node is seen.
// - Duplicate address seen stops check and sets found flag.
// - Host-not-ready set while host has not declared itself operative.
// - Bus event flag set on first CAN error, never cleared.
// - A CAN error counts in the bus-off or warning-limit counter only while that condition is flagged.
// - Fatal flag set when severe bus error stops all communication.
// - Non-exchange flag set while a configured node is not exchanging.
// - Auto-clear flag set when all nodes stopped in auto-clear end.
// - Control error flag set on own parameterization error.
// - Configured but absent node gets its no-response flag.
// - Emergency buffer per node; overflow sets node overflow flag.
// - Profile or device type mismatch sets parameterization fault.
// - Produced or consumed size mismatch sets configuration fault.
// - Node needing UCMM gets its UCMM support flag.
// - Node configured deactivated gets its deactivated flag.
// - Faulty station address and error code reported together.
// - Bus error counter and rejected telegram counter kept.
`ifndef FBS_DEFS_SVH
`define FBS_DEFS_SVH
`define FBS_NODES 64
`define FBS_ADDR_W 6
`define FBS_CNT_W 16
`define FBS_CODE_W 8
`define FBS_EMCY_DEPTH 4
`define FBS_EMCY_W 3
`define FBS_ID_W 32
`define FBS_SIZE_W 16
`endif

// File: fbs_pkg.sv
// Purpose: Types for the fieldbus master status flag block.
// Assumes: fbs_defs.svh is included first.
// Notes: None.
`include "fbs_defs.svh"
package fbs_pkg;
    typedef enum logic {FBS_STOP, FBS_OPERATE} fbs_main_t;
    typedef enum logic [1:0] {FBS_DUP_IDLE, FBS_DUP_RUN,
                              FBS_DUP_DONE, FBS_DUP_FAIL} fbs_dup_t;
    typedef struct packed {
        fbs_main_t main_state;
        fbs_dup_t dup;
        logic bus_event_seen;
        logic fatal_bus_error;
        logic auto_clear_stop;
        logic ctrl_error;
        logic node_not_exchanging;
        logic host_not_ready;
        logic [`FBS_CNT_W-1:0] bus_off_cnt;
        logic [`FBS_CNT_W-1:0] warn_cnt;
        logic [`FBS_CNT_W-1:0] bus_err_cnt;
        logic [`FBS_CNT_W-1:0] reject_cnt;
        logic [`FBS_ADDR_W-1:0] err_addr;
        logic [`FBS_CODE_W-1:0] err_code;
        logic [`FBS_NODES-1:0] no_resp;
        logic [`FBS_NODES-1:0] emcy_ovf;
        logic [`FBS_NODES-1:0] param_fault;
        logic [`FBS_NODES-1:0] cfg_fault;
        logic [`FBS_NODES-1:0] ucmm;
        logic [`FBS_NODES-1:0] deact;
        logic [`FBS_NODES-1:0] diag;
        logic [`FBS_NODES*`FBS_EMCY_W-1:0] emcy_fill;
    } fbs_state_t;
endpackage : fbs_pkg

// File: fbs_node_model.sv
// Purpose: Behavioural model of the slave nodes seen by the status block.
// Assumes: Levels and pulses change at the falling edge of ref_clk.
// Notes: A released node number shows the inverse of its last value.
`timescale 1ns/10ps
`include "fbs_defs.svh"
module fbs_node_model (
    input wire logic ref_clk,
    output logic [`FBS_NODES-1:0] present_nodes,
    output logic [`FBS_NODES-1:0] exchanging_nodes,
    output logic [`FBS_NODES-1:0] ucmm_required,
    output logic emcy_push,
    output logic emcy_pop,
    output logic [`FBS_ADDR_W-1:0] emcy_node
);
    initial begin
        present_nodes = '0;
        exchanging_nodes = '0;
        ucmm_required = '0;
        emcy_push = 1'b0;
        emcy_pop = 1'b0;
        emcy_node = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic set_node(input int a, input logic p, e, u);
        @(negedge ref_clk);
        present_nodes[a] = p;
        exchanging_nodes[a] = e;
        ucmm_required[a] = u;
    endtask : set_node
    // One emergency event, optionally with a drain in the same cycle.
    task automatic emcy_step(input logic [`FBS_ADDR_W-1:0] a,
                             input logic pu, po);
        @(negedge ref_clk);
        emcy_node = a;
        emcy_push = pu;
        emcy_pop = po;
        @(negedge ref_clk);
        emcy_push = 1'b0;
        emcy_pop = 1'b0;
        emcy_node = ~a;
    endtask : emcy_step
endmodule : fbs_node_model

// File: test_fieldbus_master_status_flags.sv
// Purpose: Self-checking bench of the master status flag block.
// Assumes: One cycle from input edge to registered output.
// Notes: Counter saturation is not reached; it would take 65535 events.
`timescale 1ns/10ps
`include "fbs_defs.svh"
module test_fieldbus_master_status_flags;
    logic ref_clk, arst_n, run_req, dup_check_start, dup_node_seen;
    logic dup_same_addr, host_operative, can_error, can_bus_off;
    logic can_warn_limit, telegram_rejected, severe_bus_error;
    logic auto_clear_end, param_error, err_valid, chk_valid, emcy_push;
    logic emcy_pop, operate, dup_check_active, dup_address_found;
    logic host_not_ready, bus_event_seen, fatal_bus_error, ctrl_error;
    logic node_not_exchanging, auto_clear_stop;
    logic [`FBS_ADDR_W-1:0] err_node, chk_node, emcy_node, err_addr;
    logic [`FBS_CODE_W-1:0] err_code_in, err_code;
    logic [`FBS_ID_W-1:0] chk_cfg_id, chk_act_id;
    logic [`FBS_SIZE_W-1:0] chk_cfg_size, chk_act_size;
    logic [`FBS_CNT_W-1:0] bus_off_cnt, warn_cnt, bus_err_cnt, reject_cnt;
    logic [`FBS_NODES-1:0] cfg_nodes, cfg_deact, present_nodes, no_resp;
    logic [`FBS_NODES-1:0] exchanging_nodes, ucmm_required, emcy_ovf;
    logic [`FBS_NODES-1:0] param_fault, cfg_fault, ucmm, deact;
    logic [`FBS_NODES-1:0] param_nodes, active_nodes, diag_nodes;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    fbs_status u_fbs_status (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .run_req(run_req),
        .dup_check_start(dup_check_start),
        .dup_node_seen(dup_node_seen),
        .dup_same_addr(dup_same_addr),
        .host_operative(host_operative),
        .can_error(can_error),
        .can_bus_off(can_bus_off),
        .can_warn_limit(can_warn_limit),
        .telegram_rejected(telegram_rejected),
        .severe_bus_error(severe_bus_error),
        .auto_clear_end(auto_clear_end),
        .param_error(param_error),
        .err_valid(err_valid),
        .err_node(err_node),
        .err_code_in(err_code_in),
        .cfg_nodes(cfg_nodes),
        .cfg_deact(cfg_deact),
        .present_nodes(present_nodes),
        .exchanging_nodes(exchanging_nodes),
        .ucmm_required(ucmm_required),
        .chk_valid(chk_valid),
        .chk_node(chk_node),
        .chk_cfg_id(chk_cfg_id),
        .chk_act_id(chk_act_id),
        .chk_cfg_size(chk_cfg_size),
        .chk_act_size(chk_act_size),
        .emcy_push(emcy_push),
        .emcy_pop(emcy_pop),
        .emcy_node(emcy_node),
        .operate(operate),
        .dup_check_active(dup_check_active),
        .dup_address_found(dup_address_found),
        .host_not_ready(host_not_ready),
        .bus_event_seen(bus_event_seen),
        .fatal_bus_error(fatal_bus_error),
        .node_not_exchanging(node_not_exchanging),
        .auto_clear_stop(auto_clear_stop),
        .ctrl_error(ctrl_error),
        .bus_off_cnt(bus_off_cnt),
        .warn_cnt(warn_cnt),
        .bus_err_cnt(bus_err_cnt),
        .reject_cnt(reject_cnt),
        .err_addr(err_addr),
        .err_code(err_code),
        .no_resp(no_resp),
        .emcy_ovf(emcy_ovf),
        .param_fault(param_fault),
        .cfg_fault(cfg_fault),
        .ucmm(ucmm),
        .deact(deact),
        .param_nodes(param_nodes),
        .active_nodes(active_nodes),
        .diag_nodes(diag_nodes)
    );
    fbs_node_model u_fbs_node_model (
        .ref_clk(ref_clk),
        .present_nodes(present_nodes),
        .exchanging_nodes(exchanging_nodes),
        .ucmm_required(ucmm_required),
        .emcy_push(emcy_push),
        .emcy_pop(emcy_pop),
        .emcy_node(emcy_node)
    );
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Ceiling well above the roughly 60 cycles the scenarios need.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            test_done();
        end
    end
    task automatic test_done();
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    ////////////////////////////////////////////////////////////////////////
    task automatic t_main();
        run_req = 1'b1;
        host_operative = 1'b1;
        tick(1);
        cmp(operate, 64'h1);
        cmp(host_not_ready, 64'h0);
        run_req = 1'b0;
        host_operative = 1'b0;
        tick(1);
        cmp(operate, 64'h0);
        cmp(host_not_ready, 64'h1);
    endtask : t_main
    task automatic t_dup();
        dup_check_start = 1'b1;
        tick(1);
        cmp(dup_check_active, 64'h1);
        dup_check_start = 1'b0;
        dup_node_seen = 1'b1;
        tick(1);
        cmp(dup_check_active, 64'h0);
        dup_node_seen = 1'b0;
        dup_same_addr = 1'b1;
        tick(1);
        cmp(dup_address_found, 64'h0);
        dup_same_addr = 1'b0;
        dup_check_start = 1'b1;
        tick(1);
        dup_check_start = 1'b0;
        dup_same_addr = 1'b1;
        dup_node_seen = 1'b1;
        tick(1);
        dup_same_addr = 1'b0;
        dup_node_seen = 1'b0;
        tick(2);
        cmp(dup_address_found, 64'h1);
        cmp(dup_check_active, 64'h0);
    endtask : t_dup
    task automatic t_bus();
        can_error = 1'b1;
        can_bus_off = 1'b1;
        tick(1);
        cmp(bus_event_seen, 64'h1);
        can_bus_off = 1'b0;
        can_warn_limit = 1'b1;
        tick(1);
        can_warn_limit = 1'b0;
        tick(1);
        can_error = 1'b0;
        telegram_rejected = 1'b1;
        severe_bus_error = 1'b1;
        auto_clear_end = 1'b1;
        param_error = 1'b1;
        err_valid = 1'b1;
        tick(1);
        {telegram_rejected, severe_bus_error, err_valid} = 3'h0;
        {auto_clear_end, param_error} = 2'h0;
        err_node = 6'h15;
        err_code_in = 8'ha3;
        tick(3);
        cmp(bus_event_seen, 64'h1);
        cmp(bus_err_cnt, 64'h3);
        cmp(bus_off_cnt, 64'h1);
        cmp(warn_cnt, 64'h1);
        cmp(reject_cnt, 64'h1);
        cmp(fatal_bus_error, 64'h1);
        cmp(auto_clear_stop, 64'h1);
        cmp(ctrl_error, 64'h1);
        cmp({err_addr, err_code}, 64'h2a5c);
    endtask : t_bus
    task automatic t_nodes();
        u_fbs_node_model.set_node(3, 1'b1, 1'b1, 1'b1);
        cfg_nodes = 64'h228;
        cfg_deact = 64'h200;
        tick(1);
        cmp(no_resp, 64'h20);
        cmp(node_not_exchanging, 64'h1);
        cmp(deact, 64'h200);
        cmp(ucmm, 64'h8);
        cmp(active_nodes[9], 64'h0);
        cmp(active_nodes, 64'h28);
        cmp(param_nodes, 64'h228);
        u_fbs_node_model.set_node(5, 1'b1, 1'b1, 1'b0);
        tick(1);
        cmp(no_resp, 64'h0);
        cmp(node_not_exchanging, 64'h0);
    endtask : t_nodes
    task automatic t_chk();
        chk_valid = 1'b1;
        chk_node = 6'h07;
        chk_act_id = 32'h11110002;
        tick(1);
        chk_node = 6'h08;
        chk_act_id = chk_cfg_id;
        chk_act_size = 16'h0009;
        tick(1);
        chk_valid = 1'b0;
        tick(1);
        cmp(param_fault, 64'h80);
        cmp(cfg_fault, 64'h100);
    endtask : t_chk
    task automatic t_emcy();
        repeat (4) u_fbs_node_model.emcy_step(6'h0c, 1'b1, 1'b0);
        u_fbs_node_model.emcy_step(6'h0c, 1'b1, 1'b1);
        cmp(emcy_ovf, 64'h0);
        u_fbs_node_model.emcy_step(6'h0c, 1'b1, 1'b0);
        cmp(emcy_ovf, 64'h1000);
        cmp(diag_nodes, 64'h1180);
    endtask : t_emcy
    ////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        {run_req, dup_check_start, dup_node_seen, dup_same_addr} = 4'h0;
        {host_operative, can_error, can_bus_off, can_warn_limit} = 4'h0;
        {telegram_rejected, severe_bus_error, auto_clear_end} = 3'h0;
        {param_error, err_valid, chk_valid} = 3'h0;
        {err_node, err_code_in, chk_node} = {6'h2a, 8'h5c, 6'h00};
        {cfg_nodes, cfg_deact} = '0;
        chk_cfg_id = 32'h11110001;
        chk_act_id = 32'h11110001;
        chk_cfg_size = 16'h0008;
        chk_act_size = 16'h0008;
        tick(20);
        arst_n = 1'b1;
        tick(1);
        cmp({host_not_ready, operate, bus_event_seen}, 64'h4);
        t_main();
        t_dup();
        t_bus();
        t_nodes();
        t_chk();
        t_emcy();
        arst_n = 1'b0;
        tick(2);
        cmp(bus_event_seen, 64'h0);
        cmp(emcy_ovf, 64'h0);
        cmp(host_not_ready, 64'h1);
        arst_n = 1'b1;
        tick(2);
        cmp(host_not_ready, 64'h1);
        cmp({fatal_bus_error, dup_address_found, ctrl_error}, 64'h0);
        cmp(bus_event_seen, 64'h0);
        test_done();
    end
endmodule : test_fieldbus_master_status_flags
